//--- verilog/seie_defines.svh
// Constants of the self-test error indicator encoder.
// Assumes a 10 MHz core clock and byte addresses on the register port.
`ifndef SEIE_DEFINES_SVH
`define SEIE_DEFINES_SVH

// Timebase
`define SEIE_CLK_HZ 64'd10000000
`define SEIE_ALT_US 64'd250000
`define SEIE_ALT_CYC ((`SEIE_ALT_US * `SEIE_CLK_HZ) / 64'd1000000)
`define SEIE_PER_W 24

// Fatal error codes on language, printer, user one, user two
`define SEIE_FC_CPU 4'h0
`define SEIE_FC_PROG_MEM 4'h1
`define SEIE_FC_WORK_MEM 4'h2
`define SEIE_FC_DISP_ACC 4'h3
`define SEIE_FC_DISP_TMO 4'h4
`define SEIE_FC_VEC_TMO 4'h5
`define SEIE_DATA_ALL 4'hf

// Register byte addresses
`define SEIE_A_PERIOD 8'h00
`define SEIE_A_STATUS 8'h04
`define SEIE_A_MASK 8'h08
`define SEIE_A_STATE 8'h0c

// Event bits of status and mask
`define SEIE_EV_W 2
`define SEIE_EV_FATAL 0
`define SEIE_EV_NONFATAL 1
`define SEIE_EV_NONE 2'h0

`endif

//--- verilog/seie_pkg.sv
// Types of the self-test error indicator encoder.
// Assumes seie_defines.svh is on the include path.
`include "seie_defines.svh"

package seie_pkg;

  typedef struct packed {
    logic online;
    logic local_mode;
    logic scroll_hold;
    logic language;
    logic printer;
    logic user_lamp_one;
    logic user_lamp_two;
  } seie_lamps_t;

  typedef enum logic [2:0] {
    msg_none,
    keyboard_fault_msg,
    internal_link_control_fault_msg,
    internal_link_loopback_fault_msg,
    internal_link_timeout_fault_msg,
    keys_and_link_control_fault_msg,
    keys_and_link_loopback_fault_msg,
    keys_and_link_timeout_fault_msg
  } seie_msg_t;

  typedef enum logic [1:0] {link_ok, link_control, link_loopback, link_timeout} seie_link_t;

  typedef struct packed {
    logic vram;
    logic vector;
    seie_link_t link;
    logic keys;
  } seie_nf_t;

  typedef struct packed {
    logic [3:0] code;
    logic [2:0] mem_data;
  } seie_fatal_t;

  typedef enum logic {st_run, st_halt} seie_mode_t;

  typedef struct packed {
    logic [`SEIE_PER_W-1:0] count;
    logic tick;
  } seie_tmr_state_t;

  // Read image of the state register
  typedef struct packed {
    logic halted;
    logic phase_data;
    logic blink;
    seie_msg_t msg;
    seie_fatal_t fatal;
    seie_nf_t faults;
  } seie_state_rd_t;

  typedef struct packed {
    seie_mode_t mode;
    seie_fatal_t fatal;
    seie_nf_t faults;
    logic phase_data;
    logic blink;
    logic [`SEIE_PER_W-1:0] period;
    logic [`SEIE_EV_W-1:0] status;
    logic [`SEIE_EV_W-1:0] mask;
    seie_lamps_t lamps;
    seie_msg_t msg;
    logic irq;
    logic [31:0] rdata;
  } seie_state_t;

endpackage

//--- verilog/seie_tick_gen.sv
// Shared timebase: one-cycle tick every i_period clocks.
// Assumes i_period is stable most of the time; a change takes effect at once.
`timescale 1ns/1ns
`include "seie_defines.svh"

module seie_tick_gen (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Synchronous reset, high
  input wire logic [`SEIE_PER_W-1:0] i_period, // Cycles per tick
  output logic o_tick // One-cycle tick
);

  seie_pkg::seie_tmr_state_t s;
  seie_pkg::seie_tmr_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    // Period of zero behaves as one so the timebase never stalls
    if ((s.count + `SEIE_PER_W'(1)) >= i_period) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + `SEIE_PER_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;

endmodule // seie_tick_gen

//--- verilog/seie_top.sv
// Self-test error indicator encoder: drives seven keyboard lamps and a
// screen message code from fatal and nonfatal self-test results.
// Assumes result strobes come from logic on i_clk, and a plain register
// port: one-cycle write or read strobes, read data the cycle after.
//
// Function
// R1: A fatal error halts normal operation at once into an error display only reset leaves.
// R2: While halted, two lamp messages are shown, an error code and a data code.
// R3: The error-code message lights the local lamp and puts the code on the four code lamps.
// R4: The data-code message lights the on-line lamp and the data value; scroll hold stays off.
// R5: The two fatal messages alternate about every quarter second.
// R6: Fatal codes are cpu 0000, program memory 0001, working memory 0010, display access 0011, display timeout 0100, vector timeout 0101.
// R7: Cpu, display and vector faults show data 1111; memory faults show 0 then a three-bit value.
// R8: A nonfatal error leaves the processor running with the mode lamp steadily lit.
// R9: A nonfatal error is shown on the lamps and as a screen message.
// R10: Nonfatal errors blink code lamps, never light them steadily; scroll hold stays off.
// R11: A keyboard failure blinks user lamp two and selects the keyboard screen message.
// R12: Language, printer, user one and user two blink for video memory, vector, link and keyboard.
// R13: The screen message names the link failure type, with a keyboard variant.
// R14: Only video memory or vector faults blink lamps with no screen message.
// R15: All blinking shares one timebase whose half-period is programmable, default a quarter second.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "seie_defines.svh"

module seie_top #(
  parameter logic [`SEIE_PER_W-1:0] ALT_CYCLES = `SEIE_PER_W'(`SEIE_ALT_CYC)
) (
  input wire logic i_clk, // Core clock, 10 MHz
  input wire logic i_rst, // Synchronous reset, high
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Register write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after i_rd
  input wire logic i_fatal, // Fatal result strobe
  input wire seie_pkg::seie_fatal_t i_fatal_info, // Fatal code and memory data
  input wire logic i_nf_report, // Nonfatal result strobe
  input wire seie_pkg::seie_nf_t i_nf, // Nonfatal failing units
  input wire logic i_online, // Mode: 1 on-line, 0 local
  output seie_pkg::seie_lamps_t o_lamps, // Keyboard indicator lamps
  output seie_pkg::seie_msg_t o_screen_msg, // Centred screen message code
  output logic o_halt, // Stop normal operation
  output logic o_irq // Unmasked event pending
);

  seie_pkg::seie_state_t s;
  seie_pkg::seie_state_t next_s;
  logic tick;

  // Single timebase: both alternation and blinking follow it
  seie_tick_gen u_tick (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_period(s.period),
    .o_tick(tick)
  ); // see R15

  // Screen message for a set of nonfatal faults
  function automatic seie_pkg::seie_msg_t msg_of(input seie_pkg::seie_nf_t f);
    seie_pkg::seie_msg_t m;
    m = seie_pkg::msg_none;
    unique case (f.link)
      seie_pkg::link_ok: begin
        if (f.keys) begin
          m = seie_pkg::keyboard_fault_msg; // see R11
        end else begin
          m = seie_pkg::msg_none; // see R14
        end
      end
      seie_pkg::link_control: begin
        m = f.keys ? seie_pkg::keys_and_link_control_fault_msg
                   : seie_pkg::internal_link_control_fault_msg; // see R13
      end
      seie_pkg::link_loopback: begin
        m = f.keys ? seie_pkg::keys_and_link_loopback_fault_msg
                   : seie_pkg::internal_link_loopback_fault_msg; // see R13
      end
      seie_pkg::link_timeout: begin
        m = f.keys ? seie_pkg::keys_and_link_timeout_fault_msg
                   : seie_pkg::internal_link_timeout_fault_msg; // see R13
      end
    endcase
    return m;
  endfunction

  // Data code for a fatal error
  function automatic logic [3:0] data_of(input seie_pkg::seie_fatal_t f);
    logic [3:0] d;
    d = `SEIE_DATA_ALL;
    if (f.code == `SEIE_FC_PROG_MEM || f.code == `SEIE_FC_WORK_MEM) begin
      d = {1'b0, f.mem_data}; // see R7
    end
    return d;
  endfunction

  seie_pkg::seie_nf_t nf_merged;
  seie_pkg::seie_state_rd_t state_rd;
  logic [3:0] code_lamps;
  logic [`SEIE_EV_W-1:0] ev;

  always_comb begin
    next_s = s;
    ev = `SEIE_EV_NONE;
    code_lamps = 4'h0;

    // Nonfatal faults accumulate until reset
    nf_merged = s.faults;
    if (i_nf_report && s.mode == seie_pkg::st_run) begin
      nf_merged.vram = s.faults.vram | i_nf.vram;
      nf_merged.vector = s.faults.vector | i_nf.vector;
      nf_merged.keys = s.faults.keys | i_nf.keys;
      // First reported link failure type is kept
      if (s.faults.link == seie_pkg::link_ok) begin
        nf_merged.link = i_nf.link;
      end
      if (i_nf.vram || i_nf.vector || i_nf.keys || i_nf.link != seie_pkg::link_ok) begin
        ev[`SEIE_EV_NONFATAL] = 1'b1;
      end
    end
    next_s.faults = nf_merged;

    unique case (s.mode)
      seie_pkg::st_run: begin
        if (i_fatal) begin
          next_s.mode = seie_pkg::st_halt; // see R1
          next_s.fatal = i_fatal_info; // see R6
          next_s.phase_data = 1'b0;
          ev[`SEIE_EV_FATAL] = 1'b1;
        end
      end
      seie_pkg::st_halt: begin
        // No exit other than reset
        next_s.mode = seie_pkg::st_halt; // see R1
        if (tick) begin
          next_s.phase_data = ~s.phase_data; // see R2 R5
        end
      end
    endcase

    if (tick) begin
      next_s.blink = ~s.blink; // see R15
    end

    // Lamp and message image, registered so the outputs are glitch free
    if (next_s.mode == seie_pkg::st_halt) begin
      if (next_s.phase_data) begin
        code_lamps = data_of(next_s.fatal); // see R4 R7
      end else begin
        code_lamps = next_s.fatal.code; // see R3 R6
      end
      // Error code shows local, data code shows on-line
      next_s.lamps.online = next_s.phase_data; // see R4
      next_s.lamps.local_mode = ~next_s.phase_data; // see R3
      next_s.lamps.scroll_hold = 1'b0; // see R4
      next_s.lamps.language = code_lamps[3];
      next_s.lamps.printer = code_lamps[2];
      next_s.lamps.user_lamp_one = code_lamps[1];
      next_s.lamps.user_lamp_two = code_lamps[0];
      // Screen holds garbage when halted; no message is driven
      next_s.msg = seie_pkg::msg_none;
    end else begin
      next_s.lamps.online = i_online; // see R8
      next_s.lamps.local_mode = ~i_online; // see R8
      next_s.lamps.scroll_hold = 1'b0; // see R10
      next_s.lamps.language = nf_merged.vram & next_s.blink; // see R10 R12
      next_s.lamps.printer = nf_merged.vector & next_s.blink; // see R12
      next_s.lamps.user_lamp_one =
        (nf_merged.link != seie_pkg::link_ok) & next_s.blink; // see R12
      next_s.lamps.user_lamp_two = nf_merged.keys & next_s.blink; // see R11 R12
      next_s.msg = msg_of(nf_merged); // see R9
    end

    // Register writes; a new event wins over a clear in the same cycle
    next_s.status = s.status;
    if (i_wr) begin
      unique case (i_addr)
        `SEIE_A_PERIOD: begin
          next_s.period = i_wdata[`SEIE_PER_W-1:0]; // see R15
        end
        `SEIE_A_STATUS: begin
          next_s.status = s.status & ~i_wdata[`SEIE_EV_W-1:0];
        end
        `SEIE_A_MASK: begin
          next_s.mask = i_wdata[`SEIE_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    next_s.status = next_s.status | ev;
    next_s.irq = |(next_s.status & next_s.mask);

    // Register reads; unmapped addresses read zero
    state_rd.halted = (s.mode == seie_pkg::st_halt);
    state_rd.phase_data = s.phase_data;
    state_rd.blink = s.blink;
    state_rd.msg = s.msg;
    state_rd.fatal = s.fatal;
    state_rd.faults = s.faults;
    next_s.rdata = 32'h0;
    if (i_rd) begin
      unique case (i_addr)
        `SEIE_A_PERIOD: next_s.rdata = 32'(s.period);
        `SEIE_A_STATUS: next_s.rdata = 32'(s.status);
        `SEIE_A_MASK: next_s.rdata = 32'(s.mask);
        `SEIE_A_STATE: next_s.rdata = 32'(state_rd);
        default: next_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
      s.mode <= seie_pkg::st_run;
      s.msg <= seie_pkg::msg_none;
      s.period <= ALT_CYCLES; // see R15
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_lamps = s.lamps;
  assign o_screen_msg = s.msg;
  assign o_halt = (s.mode == seie_pkg::st_halt); // see R1
  assign o_irq = s.irq;

endmodule // seie_top

//--- testbench/seie_properties.sv
// Checker for the indicator encoder lamp and message outputs.
// Assumes binding to seie_top; one clock, synchronous reset.
`timescale 1ns/1ns
module seie_props #(
  parameter logic [23:0] ALT_CYCLES = 24'h8
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_fatal, // Fatal strobe
  input wire seie_pkg::seie_fatal_t i_fatal_info, // Fatal info
  input wire logic i_nf_report, // Nonfatal strobe
  input wire seie_pkg::seie_nf_t i_nf, // Nonfatal units
  input wire logic i_online, // Mode
  input wire seie_pkg::seie_lamps_t o_lamps, // Lamps
  input wire seie_pkg::seie_msg_t o_screen_msg, // Message
  input wire logic o_halt // Halt
);
  // Lit run length of the code lamps; a steady lamp outgrows the period
  logic [23:0] lit_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst || o_halt || o_lamps[3:0] == 4'h0) lit_cnt <= 24'h0;
    else lit_cnt <= lit_cnt + 24'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_halt_holds: assert property (o_halt |=> o_halt)
    else $error("halt dropped");
  a_fatal_halts: assert property (i_fatal |=> o_halt)
    else $error("fatal did not halt");
  a_halt_no_msg: assert property (o_halt |-> o_screen_msg == seie_pkg::msg_none)
    else $error("message while halted");
  a_scroll_stays_off: assert property (!o_lamps.scroll_hold)
    else $error("scroll lamp lit");
  a_two_msgs: assert property (o_halt |-> o_lamps.online ^ o_lamps.local_mode)
    else $error("halt mode lamps wrong");
  a_error_code_first: assert property (i_fatal && !o_halt |=> o_lamps.local_mode &&
    !o_lamps.online && o_lamps[3:0] == $past(i_fatal_info[6:3])) else $error("error code wrong");
  a_data_code_val: assert property (o_halt && o_lamps.online |->
    o_lamps[3:0] == 4'hf || !o_lamps.language) else $error("data code wrong");
  a_mode_lamp_run: assert property (!o_halt && !$past(i_rst) |->
    o_lamps.online == $past(i_online) && o_lamps.local_mode != $past(i_online))
    else $error("mode lamp wrong");
  a_blink_not_steady: assert property (lit_cnt <= ALT_CYCLES)
    else $error("code lamp steady");
  a_keys_msg: assert property (i_nf_report && i_nf.keys && !i_fatal && !o_halt |=>
    o_screen_msg == seie_pkg::keyboard_fault_msg ||
    o_screen_msg >= seie_pkg::keys_and_link_control_fault_msg) else $error("no keyboard message");
  c_halt: cover property ($rose(o_halt));
  c_data_phase: cover property (o_halt && o_lamps.online);
  c_keys_timeout: cover property (o_screen_msg == seie_pkg::keys_and_link_timeout_fault_msg);
endmodule // seie_props

//--- testbench/seie_panel_model.sv
// Stand-in for the keyboard lamps: notes which code lamps lit and which never went dark.
// Assumes lamps change on the core clock; i_clr restarts the window.
`timescale 1ns/1ns
module seie_panel_model (
  input wire logic i_clk, // Clock
  input wire logic i_clr, // Restart observation
  input wire seie_pkg::seie_lamps_t i_lamps, // Lamps
  output logic [3:0] o_seen, // Code lamps ever lit
  output logic [3:0] o_steady // Code lamps never dark
);
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      o_seen <= 4'h0;
      o_steady <= 4'hf;
    end else begin
      o_seen <= o_seen | i_lamps[3:0];
      o_steady <= o_steady & i_lamps[3:0];
    end
  end
endmodule // seie_panel_model

//--- testbench/seie_top_tb.sv
// Self-checking bench for the indicator encoder.
// Assumes package, encoder, panel model and checker compile first.
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module seie_top_tb;
  localparam logic [23:0] ALT = 24'h8; // Short timebase keeps the run brief
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_fatal = 1'b0;
  seie_pkg::seie_fatal_t i_fatal_info = '0;
  logic i_nf_report = 1'b0;
  seie_pkg::seie_nf_t i_nf = '0;
  logic i_online = 1'b0;
  logic [31:0] o_rdata;
  seie_pkg::seie_lamps_t o_lamps;
  seie_pkg::seie_msg_t o_screen_msg;
  logic o_halt;
  logic o_irq;
  logic clr = 1'b1;
  logic [3:0] seen;
  logic [3:0] steady;
  int err_total = 0;
  int checks = 0;
  always #50 i_clk = ~i_clk;
  seie_top #(.ALT_CYCLES(ALT)) seie_top_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_fatal, .i_fatal_info, .i_nf_report, .i_nf, .i_online, .o_lamps,
    .o_screen_msg, .o_halt, .o_irq);
  seie_panel_model seie_panel_model_i (.i_clk, .i_clr(clr), .i_lamps(o_lamps), .o_seen(seen),
    .o_steady(steady));
  task automatic finish_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset(input logic online);
    @(posedge i_clk);
    i_rst <= 1'b1;
    clr <= 1'b1;
    i_online <= online;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic report_nf(input seie_pkg::seie_nf_t nf);
    @(posedge i_clk);
    i_nf_report <= 1'b1;
    i_nf <= nf;
    @(posedge i_clk);
    i_nf_report <= 1'b0;
    #1;
  endtask
  task automatic t_nonfatal;
    seie_pkg::seie_nf_t nf;
    logic [2:0] m;
    logic [4:0] tbl [9] = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h13, 5'h1d, 5'h0f, 5'h18, 5'h08};
    for (int k = 0; k < 9; k++) begin
      do_reset(k[0]);
      nf = tbl[k];
      report_nf(nf);
      m = (nf.link == seie_pkg::link_ok) ? {2'h0, nf.keys} : (nf.keys ? 3'h4 : 3'h1) + nf.link;
      `CHK("screen msg", m, o_screen_msg)
      `CHK("halt", 1'b0, o_halt)
      @(posedge i_clk) clr <= 1'b0;
      repeat (20) @(posedge i_clk);
      #1;
      `CHK("lit lamps", {nf.vram, nf.vector, nf.link != 2'h0, nf.keys}, seen)
      `CHK("steady lamps", 4'h0, steady)
      `CHK("mode lamps", {k[0], ~k[0]}, {o_lamps.online, o_lamps.local_mode})
    end
  endtask
  task automatic t_irq;
    logic [31:0] d;
    do_reset(1'b1);
    report_nf(5'h01);
    `CHK("irq masked", 1'b0, o_irq)
    reg_rd(8'h04, d);
    `CHK("status", 32'h2, d)
    reg_wr(8'h08, 32'h2);
    @(posedge i_clk);
    #1;
    `CHK("irq", 1'b1, o_irq)
    reg_wr(8'h04, 32'h2);
    @(posedge i_clk);
    #1;
    `CHK("irq cleared", 1'b0, o_irq)
    reg_rd(8'h10, d);
    `CHK("unmapped", 32'h0, d)
    reg_rd(8'h00, d);
    `CHK("period", {8'h0, ALT}, d)
    reg_wr(8'h00, 32'h3);
    reg_rd(8'h00, d);
    `CHK("period new", 32'h3, d)
  endtask
  task automatic t_fatal;
    seie_pkg::seie_fatal_t f;
    logic [3:0] dat;
    logic [31:0] d;
    int n;
    for (int c = 0; c < 6; c++) begin
      do_reset(1'b1);
      `CHK("halt cleared", 1'b0, o_halt)
      f = {c[3:0], 3'h5 - c[2:0]};
      dat = (c == 1 || c == 2) ? {1'b0, f.mem_data} : 4'hf;
      @(posedge i_clk);
      i_fatal <= 1'b1;
      i_fatal_info <= f;
      @(posedge i_clk);
      i_fatal <= 1'b0;
      #1;
      `CHK("halt", 1'b1, o_halt)
      `CHK("error msg", {3'h2, c[3:0]}, {o_lamps[6:4], o_lamps[3:0]})
      n = 0;
      while (o_lamps.online !== 1'b1 && n < 20) begin
        @(posedge i_clk);
        #1;
        n++;
      end
      if (n == 20) begin
        err_total++;
        finish_test();
      end
      `CHK("data msg", {3'h4, dat}, {o_lamps[6:4], o_lamps[3:0]})
      n = 0;
      while (o_lamps.online === 1'b1 && n < 20) begin
        @(posedge i_clk);
        #1;
        n++;
      end
      if (n == 20) begin
        err_total++;
        finish_test();
      end
      `CHK("data phase cycles", int'(ALT), n)
      report_nf(5'h1f);
      `CHK("msg in halt", seie_pkg::msg_none, o_screen_msg)
      // Report in halt must not add a nonfatal event or fault
      reg_rd(8'h04, d);
      `CHK("fatal status", 32'h1, d)
      reg_rd(8'h0c, d);
      `CHK("state", {1'b1, 3'h0, f, 5'h00}, {d[17], d[14:0]})
      reg_wr(8'h08, 32'h1);
      `CHK("fatal irq", 1'b1, o_irq)
    end
  endtask
  initial begin
    t_nonfatal();
    t_irq();
    t_fatal();
    finish_test();
  end
endmodule // seie_top_tb
bind seie_top seie_props #(.ALT_CYCLES(ALT_CYCLES)) seie_props_i (.i_clk, .i_rst, .i_fatal,
  .i_fatal_info, .i_nf_report, .i_nf, .i_online, .o_lamps, .o_screen_msg, .o_halt);
